// ### hw/tsif_cfg.svh
// register offsets, field positions and reset values of the timer/serial flag block
// assumes a byte-addressed bus with one aligned 32-bit word per register
//
// How it works
// - flags set by events, write one clears
// - underflow flags at D7, D5, D3
// - compare match flags at D6, D4
// - transmit done flag at D2
// - receive done flag at D1
// - receive error flag at D0
// - control D7 picks width, D6-D4 zero
// - control D3 gates timer0 clock output
// - read/write enable register, transmit done enable at D2 like its flag
`ifndef TSIF_CFG_SVH
`define TSIF_CFG_SVH

// byte addresses of the registers
`define TSIF_STAT_ADDR 16'hff24
`define TSIF_FLAG_ADDR 16'hff28
`define TSIF_EN_ADDR 16'hff2c
`define TSIF_CTRL_ADDR 16'hff30

// flag and enable bit positions (same layout in status and enable)
`define TSIF_BYTE_UF_BIT 7
`define TSIF_W1_MATCH_BIT 6
`define TSIF_W1_UF_BIT 5
`define TSIF_W0_MATCH_BIT 4
`define TSIF_W0_UF_BIT 3
`define TSIF_TX_DONE_BIT 2
`define TSIF_RX_DONE_BIT 1
`define TSIF_RX_ERR_BIT 0

// control register fields
`define TSIF_CTRL_WIDTH_BIT 7
`define TSIF_CTRL_CLKOUT_BIT 3

// reset values
`define TSIF_FLAG_RST 8'h00
`define TSIF_EN_RST 8'h00
`define TSIF_STAT_RST 8'h00
`define TSIF_WIDTH_RST 1'h0
`define TSIF_CLKOUT_RST 1'h0

// bus answers
`define TSIF_RESP_OKAY 2'h0
`define TSIF_RESP_SLVERR 2'h2

`endif

// ### hw/tsif_pkg.sv
// types of the timer/serial flag block
// assumes tsif_cfg.svh for the numbers
package tsif_pkg;

	// write channel progress, gray along idle -> address -> response
	typedef enum logic [1:0] {
		TSIF_WR_IDLE = 2'h0,
		TSIF_WR_HAVE_AW = 2'h1,
		TSIF_WR_RESP = 2'h3,
		TSIF_WR_HAVE_W = 2'h2
	} tsif_wr_state_t;

	typedef enum logic {
		TSIF_RD_IDLE = 1'h0,
		TSIF_RD_RESP = 1'h1
	} tsif_rd_state_t;

	// register selected by an address
	typedef enum logic [2:0] {
		TSIF_SEL_NONE = 3'h0,
		TSIF_SEL_FLAG = 3'h1,
		TSIF_SEL_EN = 3'h2,
		TSIF_SEL_STAT = 3'h3,
		TSIF_SEL_CTRL = 3'h4
	} tsif_sel_t;

	typedef struct packed {
		tsif_wr_state_t wr_state;
		tsif_rd_state_t rd_state;
		logic [15:0] aw_addr;
		logic [7:0] w_data;
		logic w_strb0;
		logic [1:0] bresp;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic timer_width_select;
		logic clk_out_enable;
		logic [7:0] irq_enable;
		logic [7:0] irq_status;
		logic clk_out;
	} tsif_state_t;

	typedef struct packed {
		logic [7:0] flags;
	} tsif_flag_state_t;

endpackage : tsif_pkg

// ### hw/tsif_flag_bank.sv
// bank of interrupt factor flags, set by events and cleared by write-one
// assumes set and clear pulses come from logic on the same clock
`timescale 1ns/1ps
`include "tsif_cfg.svh"

module tsif_flag_bank import tsif_pkg::*; #(
	parameter int WIDTH = 8
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] clr_in,
	output logic [WIDTH-1:0] flags_out
);

	tsif_flag_state_t st;
	tsif_flag_state_t next_st;
	logic [WIDTH-1:0] next_bits;

	// one flag per bit; a set in the clearing cycle wins
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_flag
			assign next_bits[gi] = set_in[gi] | (st.flags[gi] & ~clr_in[gi]);
		end
	endgenerate

	// next state copy
	always_comb begin
		next_st = st;
		next_st.flags = next_bits;
	end

	// state register, all flags read 0 after reset
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st.flags <= `TSIF_FLAG_RST;
		end else begin
			st <= next_st;
		end
	end

	assign flags_out = st.flags;

endmodule : tsif_flag_bank

// ### hw/tsif_top.sv
// timer and serial interrupt factor flags with wide timer control byte
// assumes event pulses come from timer and serial logic on clk_in,
// and an AXI4-Lite master that keeps one write and one read in flight
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tsif_cfg.svh"

module tsif_top import tsif_pkg::*; (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [15:0] s_axi_awaddr_in,
	input wire logic [2:0] s_axi_awprot_in,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	// AXI4-Lite write response
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	output logic [1:0] s_axi_bresp_out,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	input wire logic [15:0] s_axi_araddr_in,
	input wire logic [2:0] s_axi_arprot_in,
	// AXI4-Lite read data
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	// event pulses from the timers
	input wire logic byte_timer_underflow_in,
	input wire logic wide_timer1_match_in,
	input wire logic wide_timer1_underflow_in,
	input wire logic wide_timer0_match_in,
	input wire logic wide_timer0_underflow_in,
	// event pulses from the serial interface
	input wire logic serial_tx_done_in,
	input wire logic serial_rx_done_in,
	input wire logic serial_rx_error_in,
	// timer 0 output clock source
	input wire logic wide_timer0_tick_in,
	// controls toward the timers
	output logic timer_width_select_out,
	output logic wide_timer0_clk_out,
	// interrupt requests
	output logic [7:0] irq_req_out,
	output logic irq_out
);

	tsif_state_t st;
	tsif_state_t next_st;

	// flag bank wiring
	logic [7:0] event_vec;
	logic [7:0] flag_clr;
	logic [7:0] flags;

	// handshake terms
	logic aw_fire;
	logic w_fire;
	logic ar_fire;
	logic have_aw;
	logic have_w;
	logic wr_go;
	logic [15:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_strb0;
	tsif_sel_t wr_sel;
	tsif_sel_t rd_sel;
	logic [7:0] rd_clr;

	// map an address onto a register; low two bits ignored
	function automatic tsif_sel_t tsif_decode(input logic [15:0] addr);
		logic [15:0] word;
		word = {addr[15:2], 2'h0};
		case (word)
			`TSIF_FLAG_ADDR: tsif_decode = TSIF_SEL_FLAG;
			`TSIF_EN_ADDR: tsif_decode = TSIF_SEL_EN;
			`TSIF_STAT_ADDR: tsif_decode = TSIF_SEL_STAT;
			`TSIF_CTRL_ADDR: tsif_decode = TSIF_SEL_CTRL;
			default: tsif_decode = TSIF_SEL_NONE;
		endcase
	endfunction : tsif_decode

	// gather event pulses in flag layout
	always_comb begin
		event_vec = 8'h00;
		event_vec[`TSIF_BYTE_UF_BIT] = byte_timer_underflow_in;
		event_vec[`TSIF_W1_UF_BIT] = wide_timer1_underflow_in;
		event_vec[`TSIF_W0_UF_BIT] = wide_timer0_underflow_in;
		event_vec[`TSIF_W1_MATCH_BIT] = wide_timer1_match_in;
		event_vec[`TSIF_W0_MATCH_BIT] = wide_timer0_match_in;
		event_vec[`TSIF_TX_DONE_BIT] = serial_tx_done_in;
		event_vec[`TSIF_RX_DONE_BIT] = serial_rx_done_in;
		event_vec[`TSIF_RX_ERR_BIT] = serial_rx_error_in;
	end

	// channel readiness follows the write and read states
	assign s_axi_awready_out = (st.wr_state == TSIF_WR_IDLE) ||
		(st.wr_state == TSIF_WR_HAVE_W);
	assign s_axi_wready_out = (st.wr_state == TSIF_WR_IDLE) ||
		(st.wr_state == TSIF_WR_HAVE_AW);
	assign s_axi_bvalid_out = (st.wr_state == TSIF_WR_RESP);
	assign s_axi_arready_out = (st.rd_state == TSIF_RD_IDLE);
	assign s_axi_rvalid_out = (st.rd_state == TSIF_RD_RESP);

	// channel transfers this cycle
	assign aw_fire = s_axi_awvalid_in && s_axi_awready_out;
	assign w_fire = s_axi_wvalid_in && s_axi_wready_out;
	assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;

	// address and data either arrive now or were held earlier
	assign have_aw = aw_fire || (st.wr_state == TSIF_WR_HAVE_AW);
	assign have_w = w_fire || (st.wr_state == TSIF_WR_HAVE_W);
	assign wr_go = have_aw && have_w;
	assign wr_addr = aw_fire ? s_axi_awaddr_in : st.aw_addr;
	assign wr_data = w_fire ? s_axi_wdata_in[7:0] : st.w_data;
	assign wr_strb0 = w_fire ? s_axi_wstrb_in[0] : st.w_strb0;
	assign wr_sel = tsif_decode(wr_addr);
	assign rd_sel = tsif_decode(s_axi_araddr_in);

	// write-one clear toward the flag bank; a zero bit leaves its flag alone
	always_comb begin
		flag_clr = 8'h00;
		if (wr_go && wr_strb0 && (wr_sel == TSIF_SEL_FLAG)) begin
			flag_clr = wr_data;
		end
	end

	// reading the status register empties it
	assign rd_clr = (ar_fire && (rd_sel == TSIF_SEL_STAT)) ? 8'hff : 8'h00;

	// interrupt factor flags
	tsif_flag_bank #(
		.WIDTH(8)
	) u_flags (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.set_in(event_vec),
		.clr_in(flag_clr),
		.flags_out(flags)
	);

	// next state of bus, control and interrupt logic
	always_comb begin
		next_st = st;

		// write channel progress
		case (st.wr_state)
			TSIF_WR_IDLE: begin
				if (wr_go) begin
					next_st.wr_state = TSIF_WR_RESP;
				end else if (aw_fire) begin
					next_st.wr_state = TSIF_WR_HAVE_AW;
				end else if (w_fire) begin
					next_st.wr_state = TSIF_WR_HAVE_W;
				end
			end
			TSIF_WR_HAVE_AW: begin
				if (wr_go) begin
					next_st.wr_state = TSIF_WR_RESP;
				end
			end
			TSIF_WR_HAVE_W: begin
				if (wr_go) begin
					next_st.wr_state = TSIF_WR_RESP;
				end
			end
			TSIF_WR_RESP: begin
				if (s_axi_bready_in) begin
					next_st.wr_state = TSIF_WR_IDLE;
				end
			end
			default: begin
				next_st.wr_state = TSIF_WR_IDLE;
			end
		endcase

		// hold the half of a write that came first
		if (aw_fire) begin
			next_st.aw_addr = s_axi_awaddr_in;
		end
		if (w_fire) begin
			next_st.w_data = s_axi_wdata_in[7:0];
			next_st.w_strb0 = s_axi_wstrb_in[0];
		end

		// register writes once both halves are here
		if (wr_go) begin
			next_st.bresp = (wr_sel == TSIF_SEL_NONE) ? `TSIF_RESP_SLVERR : `TSIF_RESP_OKAY;
			if (wr_strb0) begin
				case (wr_sel)
					TSIF_SEL_EN: begin
						next_st.irq_enable = wr_data;
					end
					TSIF_SEL_CTRL: begin
						next_st.timer_width_select = wr_data[`TSIF_CTRL_WIDTH_BIT];
						next_st.clk_out_enable = wr_data[`TSIF_CTRL_CLKOUT_BIT];
					end
					default: begin
						next_st.irq_enable = st.irq_enable;
					end
				endcase
			end
		end

		// read channel progress and data capture
		case (st.rd_state)
			TSIF_RD_IDLE: begin
				if (ar_fire) begin
					next_st.rd_state = TSIF_RD_RESP;
					next_st.rresp = `TSIF_RESP_OKAY;
					next_st.rdata = 32'h0000_0000;
					case (rd_sel)
						TSIF_SEL_FLAG: begin
							// flags read as set or not
							next_st.rdata[7:0] = flags;
						end
						TSIF_SEL_EN: begin
							next_st.rdata[7:0] = st.irq_enable;
						end
						TSIF_SEL_STAT: begin
							next_st.rdata[7:0] = st.irq_status;
						end
						TSIF_SEL_CTRL: begin
							next_st.rdata[`TSIF_CTRL_WIDTH_BIT] = st.timer_width_select;
							next_st.rdata[`TSIF_CTRL_CLKOUT_BIT] = st.clk_out_enable;
						end
						default: begin
							next_st.rresp = `TSIF_RESP_SLVERR;
						end
					endcase
				end
			end
			TSIF_RD_RESP: begin
				if (s_axi_rready_in) begin
					next_st.rd_state = TSIF_RD_IDLE;
				end
			end
			default: begin
				next_st.rd_state = TSIF_RD_IDLE;
			end
		endcase

		// sticky status, cleared by read; a new event wins the clear
		next_st.irq_status = (st.irq_status & ~rd_clr) | event_vec;

		next_st.clk_out = st.clk_out_enable & wide_timer0_tick_in;
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st.wr_state <= TSIF_WR_IDLE;
			st.rd_state <= TSIF_RD_IDLE;
			st.aw_addr <= 16'h0000;
			st.w_data <= 8'h00;
			st.w_strb0 <= 1'h0;
			st.bresp <= `TSIF_RESP_OKAY;
			st.rresp <= `TSIF_RESP_OKAY;
			st.rdata <= 32'h0000_0000;
			st.timer_width_select <= `TSIF_WIDTH_RST;
			st.clk_out_enable <= `TSIF_CLKOUT_RST;
			st.irq_enable <= `TSIF_EN_RST;
			st.irq_status <= `TSIF_STAT_RST;
			st.clk_out <= 1'h0;
		end else begin
			st <= next_st;
		end
	end

	// registered answers and controls
	assign s_axi_bresp_out = st.bresp;
	assign s_axi_rresp_out = st.rresp;
	assign s_axi_rdata_out = st.rdata;
	assign timer_width_select_out = st.timer_width_select;
	assign wide_timer0_clk_out = st.clk_out;

	assign irq_req_out = flags & st.irq_enable;

	// summary line from the read-cleared status under the same mask
	assign irq_out = |(st.irq_status & st.irq_enable);

endmodule : tsif_top

// ### dv/tsif_top_properties.sv
// port checker of the timer/serial flag block
// assumes it is bound onto tsif_top: one clock, synchronous reset
`timescale 1ns/1ps
`include "tsif_cfg.svh"

module tsif_chk import tsif_pkg::*; (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic byte_timer_underflow_in,
	input wire logic wide_timer1_match_in,
	input wire logic wide_timer1_underflow_in,
	input wire logic wide_timer0_match_in,
	input wire logic wide_timer0_underflow_in,
	input wire logic serial_tx_done_in,
	input wire logic serial_rx_done_in,
	input wire logic serial_rx_error_in,
	input wire logic wide_timer0_tick_in,
	input wire logic timer_width_select_out,
	input wire logic wide_timer0_clk_out,
	input wire logic [7:0] irq_req_out,
	input wire logic irq_out
);
	// events in flag byte order
	wire logic [7:0] ev = {byte_timer_underflow_in, wide_timer1_match_in,
		wide_timer1_underflow_in, wide_timer0_match_in, wide_timer0_underflow_in,
		serial_tx_done_in, serial_rx_done_in, serial_rx_error_in};

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	// per-bit request changes only from an event or a taken write
	for (genvar i = 0; i < 8; i++) begin : g_bit
		AST_REQ_RISE: assert property ($rose(irq_req_out[i]) |->
			$past(ev[i]) || $rose(s_axi_bvalid_out))
			else $error("request rose without event or write");
		AST_REQ_FALL: assert property ($fell(irq_req_out[i]) |-> $rose(s_axi_bvalid_out))
			else $error("request fell without write");
	end

	AST_IRQ_RISE: assert property ($rose(irq_out) |-> $past(|ev) || $rose(s_axi_bvalid_out))
		else $error("interrupt rose without cause");
	AST_IRQ_FALL: assert property ($fell(irq_out) |->
		$rose(s_axi_bvalid_out) || $rose(s_axi_rvalid_out))
		else $error("interrupt fell without access");
	AST_WIDTH_HOLD: assert property ($changed(timer_width_select_out) |->
		$rose(s_axi_bvalid_out))
		else $error("width select changed without write");
	AST_CLKOUT_GATE: assert property (wide_timer0_clk_out |-> $past(wide_timer0_tick_in))
		else $error("clock output high without tick");
	AST_B_NEXT: assert property (s_axi_awvalid_in && s_axi_awready_out &&
		s_axi_wvalid_in && s_axi_wready_out |=> s_axi_bvalid_out)
		else $error("write response late");
	// read answered with upper bits zero
	AST_R_NEXT: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
		s_axi_rvalid_out && s_axi_rdata_out[31:8] == 24'h0)
		else $error("read answer late or wide");

	cover property ($rose(irq_out));
	cover property ($rose(timer_width_select_out));
	cover property ($fell(irq_req_out[2]));
endmodule : tsif_chk

bind tsif_top tsif_chk u_chk (.*);

// ### dv/testbench.sv
// self-checking bench of the timer/serial flag block
// assumes tsif_top with AXI4-Lite registers and 25 MHz clock
`timescale 1ns/1ps
`include "tsif_cfg.svh"

module testbench;
	logic clk_in = 1'h0;
	logic sys_rst_in = 1'h1;
	logic awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0, rrdy = 1'h0, tick = 1'h0;
	logic [15:0] awa = 16'h0, ara = 16'h0;
	logic [31:0] wd = 32'h0;
	logic [3:0] strb = 4'hf;
	logic [7:0] ev = 8'h0;
	logic awr, wrd, bv, arr, rv, wsel, clk_o, irq;
	logic [1:0] br, rr;
	logic [31:0] rdat;
	logic [7:0] req;
	int err_total = 0;
	int check_count = 0;

	tsif_top DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
		.s_axi_awprot_in(3'h0), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
		.s_axi_wdata_in(wd), .s_axi_wstrb_in(strb), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(brdy), .s_axi_bresp_out(br), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_arprot_in(3'h0),
		.s_axi_rvalid_out(rv), .s_axi_rready_in(rrdy), .s_axi_rdata_out(rdat),
		.s_axi_rresp_out(rr), .byte_timer_underflow_in(ev[7]),
		.wide_timer1_match_in(ev[6]), .wide_timer1_underflow_in(ev[5]),
		.wide_timer0_match_in(ev[4]), .wide_timer0_underflow_in(ev[3]),
		.serial_tx_done_in(ev[2]), .serial_rx_done_in(ev[1]), .serial_rx_error_in(ev[0]),
		.wide_timer0_tick_in(tick), .timer_width_select_out(wsel),
		.wide_timer0_clk_out(clk_o), .irq_req_out(req), .irq_out(irq));

	// 40 ns clock and a toggling tick source
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		tick <= ~tick;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask : chk

	// one write: address and data offered together, each dropped when taken
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
		@(posedge clk_in);
		awv <= 1'h1;
		wv <= 1'h1;
		awa <= a;
		wd <= {24'h0, d};
		brdy <= 1'h1;
		forever begin
			@(posedge clk_in);
			if (awv && awr) awv <= 1'h0;
			if (wv && wrd) wv <= 1'h0;
			if (bv) begin
				brdy <= 1'h0;
				chk("bresp", {30'h0, r}, {30'h0, br});
				break;
			end
		end
	endtask : wr

	// one read, data and response taken at the handshake edge
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] r);
		@(posedge clk_in);
		arv <= 1'h1;
		ara <= a;
		rrdy <= 1'h1;
		forever begin
			@(posedge clk_in);
			if (arv && arr) arv <= 1'h0;
			if (rv) begin
				rrdy <= 1'h0;
				chk("rdata", {24'h0, e}, rdat);
				chk("rresp", {30'h0, r}, {30'h0, rr});
				break;
			end
		end
	endtask : rd

	// one-cycle event pulse, then one edge for the flag to land
	task automatic pulse(input logic [7:0] v);
		@(posedge clk_in);
		ev <= v;
		@(posedge clk_in);
		ev <= 8'h0;
		@(posedge clk_in);
	endtask : pulse

	// clock output against the previous tick, or held low
	task automatic clk_chk(input logic on);
		repeat (4) begin
			@(posedge clk_in);
			chk("clock out", {31'h0, on && !tick}, {31'h0, clk_o});
		end
	endtask : clk_chk

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize

	// watchdog well beyond the expected run of about 260 cycles
	initial begin
		repeat (4000) @(posedge clk_in);
		err_total++;
		summarize();
	end

	initial begin
		logic [7:0] m;
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'h0;
		rd(`TSIF_FLAG_ADDR, 8'h00, `TSIF_RESP_OKAY);
		rd(`TSIF_CTRL_ADDR, 8'h00, `TSIF_RESP_OKAY);
		rd(`TSIF_EN_ADDR, 8'h00, `TSIF_RESP_OKAY);
		// each event alone: position, sticky, write-zero, write-one
		for (int i = 0; i < 8; i++) begin
			m = 8'h01 << i;
			pulse(m);
			chk("masked request", 32'h0, {24'h0, req});
			rd(`TSIF_FLAG_ADDR, m, `TSIF_RESP_OKAY);
			wr(`TSIF_FLAG_ADDR, ~m, `TSIF_RESP_OKAY);
			rd(`TSIF_FLAG_ADDR, m, `TSIF_RESP_OKAY);
			wr(`TSIF_FLAG_ADDR, m, `TSIF_RESP_OKAY);
			rd(`TSIF_FLAG_ADDR, 8'h00, `TSIF_RESP_OKAY);
			rd(`TSIF_STAT_ADDR, m, `TSIF_RESP_OKAY);
		end
		// enables, interrupt raise, mask and clear
		wr(`TSIF_EN_ADDR, 8'hff, `TSIF_RESP_OKAY);
		rd(`TSIF_EN_ADDR, 8'hff, `TSIF_RESP_OKAY);
		pulse(8'hff);
		chk("request", 32'hff, {24'h0, req});
		chk("irq", 32'h1, {31'h0, irq});
		rd(`TSIF_STAT_ADDR, 8'hff, `TSIF_RESP_OKAY);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`TSIF_EN_ADDR, 8'h04, `TSIF_RESP_OKAY);
		chk("request", 32'h04, {24'h0, req});
		wr(`TSIF_FLAG_ADDR, 8'hfb, `TSIF_RESP_OKAY);
		rd(`TSIF_FLAG_ADDR, 8'h04, `TSIF_RESP_OKAY);
		pulse(8'h01);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`TSIF_EN_ADDR, 8'h01, `TSIF_RESP_OKAY);
		chk("irq", 32'h1, {31'h0, irq});
		rd(`TSIF_STAT_ADDR, 8'h01, `TSIF_RESP_OKAY);
		chk("irq", 32'h0, {31'h0, irq});
		// control byte: width, clock gate, unused bits
		wr(`TSIF_CTRL_ADDR, 8'hff, `TSIF_RESP_OKAY);
		rd(`TSIF_CTRL_ADDR, 8'h88, `TSIF_RESP_OKAY);
		chk("width", 32'h1, {31'h0, wsel});
		clk_chk(1'h1);
		wr(`TSIF_CTRL_ADDR, 8'h08, `TSIF_RESP_OKAY);
		chk("width", 32'h0, {31'h0, wsel});
		wr(`TSIF_CTRL_ADDR, 8'h00, `TSIF_RESP_OKAY);
		clk_chk(1'h0);
		// a write with its low byte lane off changes nothing
		strb <= 4'h0;
		wr(`TSIF_CTRL_ADDR, 8'hff, `TSIF_RESP_OKAY);
		strb <= 4'hf;
		rd(`TSIF_CTRL_ADDR, 8'h00, `TSIF_RESP_OKAY);
		// unmapped place and read-only status
		wr(16'hff20, 8'hff, `TSIF_RESP_SLVERR);
		rd(16'hff20, 8'h00, `TSIF_RESP_SLVERR);
		rd(`TSIF_FLAG_ADDR, 8'h05, `TSIF_RESP_OKAY);
		wr(`TSIF_STAT_ADDR, 8'hff, `TSIF_RESP_OKAY);
		rd(`TSIF_STAT_ADDR, 8'h00, `TSIF_RESP_OKAY);
		summarize();
	end
endmodule : testbench
